// file: tsr_defs.svh
// Constants of the triggered sample recorder
// Function
// (RULE1) Four channels, 500 samples, up to 2kHz
// (RULE2) Each channel stores 16-bit samples only
// (RULE3) Mode register is readable and writable
// (RULE4) Mode 0 idles, mode 1 records continuously
// (RULE5) Mode 2 fills all 500 positions once
// (RULE6) Mode 3 samples circularly awaiting trigger
// (RULE7) After trigger take 500 minus pre-count
// (RULE8) Pre-count sets pre-trigger samples kept
// (RULE9) Report oldest sample index after triggered capture
// (RULE10) Period counts regulator cycles, full 16 bits
// (RULE11) Period zero samples every regulator cycle
// (RULE12) Trigger when status and mask share bit
// (RULE13) Channel samples readable at 1000, 2000, ...
// (RULE14) Finished capture freezes data until mode write
// (RULE15) Mode write restarts sample and wait counters
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH

// ****************************************
// Widths and sizes
// ****************************************
`define TSR_ADDR_W 13
`define TSR_DATA_W 16
`define TSR_NCH 4
`define TSR_IDX_W 9
`define TSR_DEPTH 9'h1f4
`define TSR_LAST_IDX 9'h1f3
`define TSR_DEPTH_W 10'h1f4

// ****************************************
// Register numbers
// ****************************************
`define TSR_REG_MODE 13'h0384
`define TSR_REG_MASK 13'h0385
`define TSR_REG_PERIOD 13'h0386
`define TSR_REG_PRE 13'h0387
`define TSR_REG_START 13'h0388
`define TSR_CH1_BASE 13'h03e8
`define TSR_CH2_BASE 13'h07d0
`define TSR_CH3_BASE 13'h0bb8
`define TSR_CH4_BASE 13'h0fa0

// ****************************************
// Mode values and reset values
// ****************************************
`define TSR_MODE_IDLE 16'h0000
`define TSR_MODE_CONT 16'h0001
`define TSR_MODE_SINGLE 16'h0002
`define TSR_MODE_TRIG 16'h0003
`define TSR_RST_WORD 16'h0000

// ****************************************
// Timing
// ****************************************
`define TSR_CLK_PERIOD_NS 50
`define TSR_REG_PERIOD_NS 500000
`define TSR_REG_CYCLES (`TSR_REG_PERIOD_NS / `TSR_CLK_PERIOD_NS)

`endif

// file: tsr_pkg.sv
// Types of the triggered sample recorder
package tsr_pkg;
   typedef enum logic [2:0] {
      tsr_idle,
      tsr_cont,
      tsr_single,
      tsr_armed,
      tsr_post,
      tsr_done
   } tsr_state_e;
   typedef logic [15:0] tsr_word_t;
   typedef logic [8:0]  tsr_idx_t;
endpackage

// file: tsr_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tsr_buf #(
   parameter int WIDTH = 73
) (
   input  wire logic             clk,       // System clock
   input  wire logic             rst_n,     // Async reset, active low
   input  wire logic             in_valid,  // Source offers a word
   output logic                  in_ready,  // Buffer has room
   input  wire logic [WIDTH-1:0] in_data,   // Word from source
   output logic                  out_valid, // Buffer holds a word
   input  wire logic             out_ready, // Sink takes the word
   output logic [WIDTH-1:0]      out_data   // Oldest word
);
   logic [WIDTH-1:0] ent0, ent1, next_ent0, next_ent1;
   logic [1:0]       cnt, next_cnt;
   logic             push, pop;

   // Handshakes and flags
   assign in_ready  = (cnt != 2'h2);
   assign out_valid = (cnt != 2'h0);
   assign out_data  = ent0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next entries: pop shifts, push fills the first free slot
   always_comb begin
      next_ent0 = ent0;
      next_ent1 = ent1;
      next_cnt  = cnt;
      if (pop) begin
         next_ent0 = ent1;
         next_cnt  = 2'(cnt - 2'h1);
      end
      if (push) begin
         if (next_cnt == 2'h0) begin
            next_ent0 = in_data;
         end else begin
            next_ent1 = in_data;
         end
         next_cnt = 2'(next_cnt + 2'h1);
      end
   end

   // Register the buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ent0 <= '0;
         ent1 <= '0;
         cnt  <= 2'h0;
      end else begin
         ent0 <= next_ent0;
         ent1 <= next_ent1;
         cnt  <= next_cnt;
      end
   end
endmodule
`default_nettype wire

// file: tsr_mem.sv
// Sample memory, all channels written together, one word read
`timescale 1ns/1ps
`default_nettype none
module tsr_mem #(
   parameter int W     = 16,
   parameter int N     = 4,
   parameter int DEPTH = 500,
   parameter int AW    = 9
) (
   input  wire logic           clk,      // System clock
   input  wire logic           rst_n,    // Async reset, active low
   input  wire logic           we,       // Write one row
   input  wire logic [AW-1:0]  waddr,    // Row to write
   input  wire logic [N*W-1:0] wdata,    // All channels of a row
   input  wire logic           re,       // Read one word
   input  wire logic [1:0]     rbank,    // Channel to read
   input  wire logic [AW-1:0]  raddr,    // Row to read
   input  wire logic           byp,      // Load bypass word instead
   input  wire logic [W-1:0]   byp_data, // Bypass word
   output logic [W-1:0]        q         // Registered read data
);
   logic [N*W-1:0] arr [DEPTH];
   logic [W-1:0]   next_q;

   // Row write
   always_ff @(posedge clk) begin
      if (we) begin
         arr[waddr] <= wdata;
      end
   end

   // Read word or bypass word
   always_comb begin
      next_q = q;
      if (re) begin
         next_q = arr[raddr][rbank*W +: W];
      end else if (byp) begin
         next_q = byp_data;
      end
   end

   // Read data register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule
`default_nettype wire

// file: tsr_top.sv
// Triggered sample recorder: registers, capture control, read path
`include "tsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tsr_top
   import tsr_pkg::*;
#(
   parameter int REG_CYCLES = `TSR_REG_CYCLES
) (
   input  wire logic        clk,         // 20 MHz clock
   input  wire logic        rst_n,       // Async reset, active low
   input  wire logic [12:0] addr,        // Register number
   input  wire logic [15:0] wdata,       // Write data
   input  wire logic        wr,          // Write strobe
   input  wire logic        rd,          // Read strobe
   output logic [15:0]      rdata,       // Read data, cycle after rd
   input  wire logic [15:0] status_word, // Device status bits
   input  wire logic [15:0] chan0,       // Channel 1 source value
   input  wire logic [15:0] chan1,       // Channel 2 source value
   input  wire logic [15:0] chan2,       // Channel 3 source value
   input  wire logic [15:0] chan3        // Channel 4 source value
);
   // ****************************************
   // Declarations
   // ****************************************
   tsr_state_e state, next_state;
   tsr_word_t  mode, next_mode;
   tsr_word_t  mask, next_mask;
   tsr_word_t  period, next_period;
   tsr_word_t  pre, next_pre;
   tsr_idx_t   start_idx, next_start_idx;
   tsr_idx_t   wr_idx, next_wr_idx, wr_idx_inc;
   tsr_word_t  wait_cnt, next_wait_cnt;
   logic [9:0] remain, next_remain, post_len;
   logic [13:0] div_cnt, next_div_cnt;
   logic        tick, next_tick;
   logic        mode_wr, active, counted, take, trig_hit;
   logic        buf_in_ready, buf_out_valid, buf_out_ready;
   logic [72:0] buf_out_data;
   logic        mem_re, mem_byp;
   logic [1:0]  mem_bank;
   tsr_idx_t    mem_raddr;
   tsr_word_t   byp_data;

   // ****************************************
   // Regulator cycle divider
   // ****************************************

   // One-cycle tick per regulator cycle
   always_comb begin
      next_tick    = 1'b0;
      next_div_cnt = 14'(div_cnt + 14'h1);
      if (div_cnt == 14'(REG_CYCLES - 1)) begin
         next_div_cnt = 14'h0;
         next_tick    = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 14'h0;
         tick    <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         tick    <= next_tick;
      end
   end

   // ****************************************
   // Capture control
   // ****************************************

   // Sampling decisions
   assign mode_wr  = wr && (addr == `TSR_REG_MODE);
   assign active   = (state == tsr_cont) || (state == tsr_single) ||
                     (state == tsr_armed) || (state == tsr_post);
   assign counted  = (state == tsr_single) || (state == tsr_post);
   assign take     = tick && active && (wait_cnt == 16'h0) && buf_in_ready;
   assign trig_hit = |(status_word & mask); // see RULE12
   assign post_len = (pre >= 16'(`TSR_DEPTH)) ? 10'h0 :
                     10'(`TSR_DEPTH_W - 10'(pre)); // see RULE7
   assign wr_idx_inc = (wr_idx == `TSR_LAST_IDX) ? 9'h0 :
                       9'(wr_idx + 9'h1); // see RULE1

   // Next register and capture state
   always_comb begin
      next_state     = state;
      next_mode      = mode;
      next_mask      = mask;
      next_period    = period;
      next_pre       = pre;
      next_start_idx = start_idx;
      next_wr_idx    = wr_idx;
      next_wait_cnt  = wait_cnt;
      next_remain    = remain;
      if (wr && addr == `TSR_REG_MASK) begin
         next_mask = wdata;
      end else if (wr && addr == `TSR_REG_PERIOD) begin
         next_period = wdata; // see RULE10
      end else if (wr && addr == `TSR_REG_PRE) begin
         next_pre = wdata; // see RULE8
      end
      if (mode_wr) begin
         next_mode     = wdata; // see RULE3
         next_wr_idx   = 9'h0; // see RULE15
         next_wait_cnt = 16'h0; // see RULE15
         next_remain   = `TSR_DEPTH_W; // see RULE5
         case (wdata)
            `TSR_MODE_CONT:   next_state = tsr_cont; // see RULE4
            `TSR_MODE_SINGLE: next_state = tsr_single; // see RULE5
            `TSR_MODE_TRIG:   next_state = tsr_armed; // see RULE6
            default:          next_state = tsr_idle; // see RULE4
         endcase
      end else begin
         if (take) begin
            next_wr_idx   = wr_idx_inc; // see RULE6
            next_wait_cnt = period; // see RULE11
            if (counted) begin
               next_remain = 10'(remain - 10'h1);
            end
            if (counted && remain == 10'h1) begin
               next_state     = tsr_done; // see RULE14
               next_start_idx = wr_idx_inc; // see RULE9
            end
         end else if (tick && active && wait_cnt != 16'h0) begin
            next_wait_cnt = 16'(wait_cnt - 16'h1); // see RULE10
         end
         if (state == tsr_armed && trig_hit) begin
            if (post_len == 10'h0) begin
               next_state     = tsr_done;
               next_start_idx = next_wr_idx; // see RULE9
            end else begin
               next_state  = tsr_post; // see RULE7
               next_remain = post_len;
            end
         end
      end
   end

   // Register the control state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= tsr_idle;
         mode      <= `TSR_RST_WORD;
         mask      <= `TSR_RST_WORD;
         period    <= `TSR_RST_WORD;
         pre       <= `TSR_RST_WORD;
         start_idx <= 9'h0;
         wr_idx    <= 9'h0;
         wait_cnt  <= 16'h0;
         remain    <= 10'h0;
      end else begin
         state     <= next_state;
         mode      <= next_mode;
         mask      <= next_mask;
         period    <= next_period;
         pre       <= next_pre;
         start_idx <= next_start_idx;
         wr_idx    <= next_wr_idx;
         wait_cnt  <= next_wait_cnt;
         remain    <= next_remain;
      end
   end

   // ****************************************
   // Sample path
   // ****************************************

   // Row of four 16-bit samples waits here while a read holds the memory
   tsr_buf #(
      .WIDTH (73)
   ) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (take),
      .in_ready  (buf_in_ready),
      .in_data   ({wr_idx, chan3, chan2, chan1, chan0}), // see RULE2
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data)
   );

   assign buf_out_ready = !mem_re; // see RULE13

   // ****************************************
   // Read path
   // ****************************************

   // Address decode for reads
   always_comb begin
      mem_re    = 1'b0;
      mem_byp   = 1'b0;
      mem_bank  = 2'h0;
      mem_raddr = 9'h0;
      byp_data  = 16'h0;
      if (rd && addr >= `TSR_CH1_BASE && addr < 13'(`TSR_CH1_BASE + 13'h1f4)) begin
         mem_re    = 1'b1; // see RULE13
         mem_raddr = 9'(addr - `TSR_CH1_BASE);
      end else if (rd && addr >= `TSR_CH2_BASE && addr < 13'(`TSR_CH2_BASE + 13'h1f4)) begin
         mem_re    = 1'b1; // see RULE13
         mem_bank  = 2'h1;
         mem_raddr = 9'(addr - `TSR_CH2_BASE);
      end else if (rd && addr >= `TSR_CH3_BASE && addr < 13'(`TSR_CH3_BASE + 13'h1f4)) begin
         mem_re    = 1'b1;
         mem_bank  = 2'h2;
         mem_raddr = 9'(addr - `TSR_CH3_BASE);
      end else if (rd && addr >= `TSR_CH4_BASE && addr < 13'(`TSR_CH4_BASE + 13'h1f4)) begin
         mem_re    = 1'b1;
         mem_bank  = 2'h3;
         mem_raddr = 9'(addr - `TSR_CH4_BASE);
      end else if (rd) begin
         mem_byp = 1'b1;
         if (addr == `TSR_REG_MODE) begin
            byp_data = mode; // see RULE3
         end else if (addr == `TSR_REG_MASK) begin
            byp_data = mask;
         end else if (addr == `TSR_REG_PERIOD) begin
            byp_data = period;
         end else if (addr == `TSR_REG_PRE) begin
            byp_data = pre;
         end else if (addr == `TSR_REG_START) begin
            byp_data = {7'h0, start_idx}; // see RULE9
         end
      end
   end

   // Memory output register drives rdata directly
   tsr_mem #(
      .W     (16),
      .N     (4),
      .DEPTH (500),
      .AW    (9)
   ) u_mem (
      .clk      (clk),
      .rst_n    (rst_n),
      .we       (buf_out_valid && buf_out_ready),
      .waddr    (buf_out_data[72:64]),
      .wdata    (buf_out_data[63:0]),
      .re       (mem_re),
      .rbank    (mem_bank),
      .raddr    (mem_raddr),
      .byp      (mem_byp),
      .byp_data (byp_data),
      .q        (rdata)
   );

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_single_last;
      take && state == tsr_single && remain == 10'h1 && !mode_wr;
   endsequence

   sequence s_trig_fire;
      state == tsr_armed && trig_hit && !mode_wr && post_len != 10'h0;
   endsequence

   a_mode_readback: assert property ( // see RULE3
      rd && addr == `TSR_REG_MODE |=> rdata == $past(mode))
      else $error("mode readback wrong");
   a_idle_no_take: assert property ( // see RULE4
      (state == tsr_idle || state == tsr_done) && !mode_wr |=> $stable(wr_idx) &&
      $stable(wait_cnt))
      else $error("sample taken while idle");
   a_index_wrap: assert property ( // see RULE1
      take && wr_idx == `TSR_LAST_IDX && !mode_wr |=> wr_idx == 9'h0)
      else $error("index did not wrap at 499");
   a_single_done: assert property ( // see RULE5
      s_single_last |=> state == tsr_done && start_idx == 9'h0)
      else $error("single pass did not end at 500");
   a_post_count: assert property ( // see RULE7
      s_trig_fire |=> state == tsr_post && remain == $past(post_len))
      else $error("post trigger count wrong");
   a_trig_leave: assert property ( // see RULE12
      state == tsr_armed && trig_hit && !mode_wr |=> state != tsr_armed)
      else $error("trigger ignored");
   // A mode write or a tick right after the sample may move the wait counter
   a_period_load: assert property ( // see RULE10
      take && !mode_wr |=> wait_cnt == $past(period) ##1
      ($past(mode_wr) || $past(tick) || wait_cnt == $past(period, 2)))
      else $error("period wait not loaded");
   a_period_zero: assert property ( // see RULE11
      period == 16'h0 && take && !mode_wr |=> wait_cnt == 16'h0)
      else $error("period zero skipped a cycle");
   a_done_frozen: assert property ( // see RULE14
      state == tsr_done && !mode_wr |=> state == tsr_done && $stable(wr_idx) &&
      $stable(start_idx))
      else $error("finished capture changed");
   a_mode_restart: assert property ( // see RULE15
      mode_wr |=> wr_idx == 9'h0 && wait_cnt == 16'h0)
      else $error("counters not restarted");
   a_read_stall: assert property ( // see RULE13
      mem_re && buf_out_valid |=> buf_out_valid)
      else $error("row lost during channel read");
endmodule
`default_nettype wire

// file: tsr_tb.sv
// Self-checking testbench of the triggered sample recorder
`include "tsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int RC = 8; // Short regulator cycle for simulation

   logic        clk;
   logic        rst_n;
   logic [12:0] addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic [15:0] status_word;
   logic [15:0] cyc = 16'h0000;
   int          bad_count = 0;
   int          num_checks = 0;
   logic [15:0] smp [0:3][0:499];

   // ****************************************
   // Design, channels fed from a cycle count
   // ****************************************
   tsr_top #(.REG_CYCLES(RC)) dut_u (
      .clk         (clk),
      .rst_n       (rst_n),
      .addr        (addr),
      .wdata       (wdata),
      .wr          (wr),
      .rd          (rd),
      .rdata       (rdata),
      .status_word (status_word),
      .chan0       (cyc),
      .chan1       (~cyc),
      .chan2       (cyc ^ 16'h5a5a),
      .chan3       (cyc + 16'h1000)
   );

   // Clock and the free-running sample source
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 16'h0001;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One-cycle write strobe
   task automatic wr_reg(input logic [12:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // One-cycle read strobe, data taken in the following cycle only
   task automatic rd_reg(input logic [12:0] a, output logic [15:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // Read all channels; a row holds all four channels of one instant
   task automatic dump;
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 500; i++) begin
            rd_reg(13'(`TSR_CH1_BASE + c * 1000 + i), smp[c][i]);
         end
      end
      for (int i = 0; i < 500; i++) begin
         chk(smp[1][i], ~smp[0][i]);
         chk(smp[2][i], smp[0][i] ^ 16'h5a5a);
         chk(smp[3][i], smp[0][i] + 16'h1000);
      end
   endtask

   // Record from the oldest slot onwards must step evenly
   task automatic chk_steps(input int s, input logic [15:0] step);
      for (int i = 0; i < 499; i++) begin
         chk(smp[0][(s + i + 1) % 500] - smp[0][(s + i) % 500], step);
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      logic [15:0] v;
      for (int a = 0; a < 5; a++) begin
         rd_reg(13'(`TSR_REG_MODE + a), v);
         chk(v, `TSR_RST_WORD);
      end
      rd_reg(13'h0389, v);
      chk(v, 16'h0000);
      wr_reg(`TSR_REG_START, 16'h0123);
      rd_reg(`TSR_REG_START, v);
      chk(v, 16'h0000);
      wr_reg(`TSR_REG_MASK, 16'ha5c3);
      rd_reg(`TSR_REG_MASK, v);
      chk(v, 16'ha5c3);
      wr_reg(`TSR_REG_PERIOD, 16'hffff);
      rd_reg(`TSR_REG_PERIOD, v);
      chk(v, 16'hffff);
      wr_reg(`TSR_REG_PRE, 16'h01f3);
      rd_reg(`TSR_REG_PRE, v);
      chk(v, 16'h01f3);
      for (int m = 0; m < 5; m++) begin
         wr_reg(`TSR_REG_MODE, (m == 4) ? 16'h0007 : 16'(m));
         rd_reg(`TSR_REG_MODE, v);
         chk(v, (m == 4) ? 16'h0007 : 16'(m));
      end
      wr_reg(`TSR_REG_MODE, `TSR_MODE_IDLE);
   endtask

   task automatic t_single;
      logic [15:0] v;
      wr_reg(`TSR_REG_PERIOD, 16'h0001);
      wr_reg(`TSR_REG_MODE, `TSR_MODE_SINGLE);
      wait_cyc(500 * 2 * RC + 40);
      rd_reg(`TSR_REG_START, v);
      chk(v, 16'h0000);
      rd_reg(`TSR_CH1_BASE, v);
      wait_cyc(30 * RC);
      dump();
      chk(smp[0][0], v);
      chk_steps(0, 16'(2 * RC));
   endtask

   task automatic t_cont;
      logic [15:0] v;
      logic [15:0] v2;
      wr_reg(`TSR_REG_PERIOD, 16'h0000);
      wr_reg(`TSR_REG_MODE, `TSR_MODE_CONT);
      wait_cyc(600 * RC);
      rd_reg(`TSR_CH1_BASE, v);
      chk(16'((cyc - v) < 16'(500 * RC + 4)), 16'h0001);
      wr_reg(`TSR_REG_MODE, `TSR_MODE_IDLE);
      wait_cyc(4);
      rd_reg(`TSR_CH1_BASE, v);
      wait_cyc(600 * RC);
      rd_reg(`TSR_CH1_BASE, v2);
      chk(v2, v);
   endtask

   task automatic t_trig;
      logic [15:0] s;
      logic [15:0] tc;
      logic [15:0] d;
      wr_reg(`TSR_REG_MASK, 16'h0010);
      wr_reg(`TSR_REG_PRE, 16'h0064);
      wr_reg(`TSR_REG_MODE, `TSR_MODE_TRIG);
      @(posedge clk);
      status_word <= 16'h0001;                   // Unmasked bit only
      wait_cyc(600 * RC);
      status_word <= 16'h0011;
      tc = cyc;
      wait_cyc(500 * RC + 40);
      status_word <= 16'h0000;
      rd_reg(`TSR_REG_START, s);
      dump();
      chk_steps(int'(s), 16'(RC));
      d = tc - smp[0][(s + 99) % 500];
      chk(16'((d + 16'd1) < 16'(RC)), 16'h0001);
   endtask

   // Pre-count of 500 ends the capture at the trigger itself
   task automatic t_trig_full;
      logic [15:0] s;
      logic [15:0] tc;
      logic [15:0] v;
      wr_reg(`TSR_REG_PRE, 16'h01f4);
      wr_reg(`TSR_REG_MODE, `TSR_MODE_TRIG);
      wait_cyc(100 * RC);
      status_word <= 16'h0010;
      tc = cyc;
      wait_cyc(2 * RC);
      status_word <= 16'h0000;
      rd_reg(`TSR_REG_START, s);
      rd_reg(13'(`TSR_CH1_BASE + (s + 499) % 500), v);
      chk(16'((tc - v + 16'd1) < 16'(RC)), 16'h0001);
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      rst_n       = 1'b0;
      addr        = 13'h0000;
      wdata       = 16'h0000;
      wr          = 1'b0;
      rd          = 1'b0;
      status_word = 16'h0000;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_single();
      t_cont();
      t_trig();
      t_trig_full();
      finish_test();
   end

   initial begin
      repeat (80000) @(posedge clk);
      bad_count++;
      finish_test();
   end
endmodule
`default_nettype wire
